// *** src/bsc_pkg.sv ***
package bsc_pkg;
  // core address width and byte lanes of the array behind this block
  localparam int         BSC_ADDR_W            = 20;
  localparam int         BSC_BYTES             = 4;
  localparam int         BSC_CLK_MHZ           = 125;
  // wake-up: cycles spent in the wake state, after the synchronized request falls, before normal operation resumes
  localparam int         BSC_SLEEP_EXIT_CYC    = 2;
  // recovery window after wake, least time rounded up to whole cycles
  localparam int         BSC_WAKE_RECOVERY_NS  = 20;
  localparam int         BSC_WAKE_RECOVERY_CYC =
    (BSC_WAKE_RECOVERY_NS * BSC_CLK_MHZ + 999) / 1000;

  localparam logic [3:0] BSC_OFF_CTRL          = 4'h0;
  localparam logic [3:0] BSC_OFF_STATUS        = 4'h4;
  localparam logic [3:0] BSC_OFF_ADDR          = 4'h8;
  localparam logic [3:0] BSC_OFF_EVENT         = 4'hC;
  localparam int         BSC_CTRL_BLOCK_BIT    = 0;
  localparam logic       BSC_CTRL_BLOCK_RST    = 1'h1;
  localparam int         BSC_EVT_REC_WR_BIT    = 0;
  localparam int         BSC_EVT_CUT_BIT       = 1;
  localparam int         BSC_EVT_W             = 2;

  typedef enum logic [1:0] {BSC_RW_DESEL, BSC_RW_READ, BSC_RW_WRITE} bsc_rw_t;
  typedef enum logic [1:0] {BSC_SL_ACTIVE, BSC_SL_SLEEP, BSC_SL_WAKE} bsc_sleep_t;

  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [BSC_BYTES-1:0]  byte_en;
    logic [BSC_ADDR_W-1:0] addr;
  } bsc_core_req_t;

  typedef struct packed {
    logic [1:0] burst_cnt;
    logic       order;
    logic       pipelined;
    logic       recovering;
    logic       asleep;
    bsc_rw_t    rw;
  } bsc_status_t;

  localparam int BSC_STATUS_W = $bits(bsc_status_t);

  // low address bits of a beat: linear adds, interleaved xors
  function automatic logic [1:0] bsc_burst_low(input logic       order,
                                               input logic [1:0] base,
                                               input logic [1:0] cnt);
    return order ? (base ^ cnt) : (base + cnt); // RULE5
  endfunction : bsc_burst_low
endpackage : bsc_pkg

// *** src/bsc_burst_gen.sv ***
`timescale 1ns/100ps
module bsc_burst_gen
  import bsc_pkg::*;
#(
  parameter int ADDR_W = BSC_ADDR_W  // address width, more than 2
) (
  input  wire logic              i_sys_clk, // system clock
  input  wire logic              i_reset,   // async reset, high
  input  wire logic              i_load,    // load start address
  input  wire logic              i_step,    // advance one beat
  input  wire logic              i_order,   // high: interleaved
  input  wire logic [ADDR_W-1:0] i_addr,    // external start address
  output logic      [ADDR_W-1:0] o_addr,    // address of this cycle
  output logic      [1:0]        o_count    // beats since load, mod 4
);
  logic [1:0] base_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  assign cnt_d   = cnt_q + 2'h1; // RULE15
  assign o_count = cnt_q;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      base_q <= 2'h0;
      cnt_q  <= 2'h0;
    end else if (i_load) begin
      base_q <= i_addr[1:0];
      cnt_q  <= 2'h0;
    end else if (i_step) begin
      cnt_q <= cnt_d; // RULE3
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_addr <= '0;
    end else if (i_load) begin
      o_addr <= i_addr; // RULE2
    end else if (i_step) begin
      o_addr <= {o_addr[ADDR_W-1:2], bsc_burst_low(i_order, base_q, cnt_d)}; // RULE19
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  a_wrap_four: assert property ( // RULE3
    (i_step && !i_load && $stable(i_order)) [*4] |=> o_addr == $past(o_addr, 4))
    else $error("burst did not wrap after four beats");
  a_linear_next: assert property ( // RULE4
    i_step && !i_load && !i_order && $stable(i_order)
    |=> o_addr[1:0] == $past(o_addr[1:0]) + 2'h1)
    else $error("linear beat is not previous plus one");
  a_inter_next: assert property ( // RULE5
    i_step && !i_load && i_order |=> o_addr[1:0] == bsc_burst_low(1'b1, base_q, o_count))
    else $error("interleaved beat is not base xor count");
  a_upper_keep: assert property ( // RULE19
    i_step && !i_load |=> o_addr[ADDR_W-1:2] == $past(o_addr[ADDR_W-1:2]))
    else $error("upper address bits moved during a burst");
endmodule : bsc_burst_gen

// *** src/bsc_sleep_ctl.sv ***
`timescale 1ns/100ps
module bsc_sleep_ctl
  import bsc_pkg::*;
(
  input  wire logic i_sys_clk,       // system clock
  input  wire logic i_reset,         // async reset, high
  input  wire logic i_sleep_request, // asynchronous, high: sleep
  output logic      o_asleep,        // high: inputs ignored
  output logic      o_recovering,    // high: recovery window
  output logic      o_sleep_start    // pulse: sleep taken next edge
);
  localparam int EXIT_W = $clog2(BSC_SLEEP_EXIT_CYC + 1);
  localparam int REC_W  = $clog2(BSC_WAKE_RECOVERY_CYC + 1);
  localparam logic [EXIT_W-1:0] EXIT_LAST = EXIT_W'(BSC_SLEEP_EXIT_CYC - 1);
  localparam logic [REC_W-1:0]  REC_LOAD  = REC_W'(BSC_WAKE_RECOVERY_CYC);

  logic              sync1_q;
  logic              sync2_q;
  bsc_sleep_t        state_q;
  logic [EXIT_W-1:0] exit_cnt_q;
  logic [REC_W-1:0]  rec_cnt_q;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= i_sleep_request; // RULE7
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q    <= BSC_SL_ACTIVE;
      exit_cnt_q <= '0;
    end else begin
      case (state_q)
        BSC_SL_ACTIVE: if (sync2_q) state_q <= BSC_SL_SLEEP; // RULE8
        BSC_SL_SLEEP: if (!sync2_q) begin
          state_q    <= BSC_SL_WAKE;
          exit_cnt_q <= '0;
        end
        BSC_SL_WAKE: if (sync2_q) begin
          state_q <= BSC_SL_SLEEP;
        end else if (exit_cnt_q == EXIT_LAST) begin
          state_q <= BSC_SL_ACTIVE; // RULE11
        end else begin
          exit_cnt_q <= exit_cnt_q + 1'b1;
        end
        default: state_q <= BSC_SL_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) rec_cnt_q <= '0;
    else if (state_q == BSC_SL_WAKE) rec_cnt_q <= REC_LOAD;
    else if (rec_cnt_q != '0) rec_cnt_q <= rec_cnt_q - 1'b1;
  end

  assign o_asleep      = state_q != BSC_SL_ACTIVE;
  assign o_recovering  = (state_q == BSC_SL_ACTIVE) && (rec_cnt_q != '0);
  assign o_sleep_start = (state_q == BSC_SL_ACTIVE) && sync2_q;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  a_sleep_entry: assert property ( // RULE8
    i_sleep_request [*3] |=> o_asleep)
    else $error("sleep not entered after request held");
  a_wake_time: assert property ( // RULE11
    $fell(o_asleep) |-> $past(state_q == BSC_SL_WAKE, 2) && $past(state_q == BSC_SL_SLEEP, 3))
    else $error("wake-up did not take two cycles");
endmodule : bsc_sleep_ctl

// *** src/bsc_top.sv ***
// Operation
// [RULE1] step high advances counter, uses counted address
// [RULE2] step low loads external start address
// [RULE3] counter wraps to loaded value after four
// [RULE4] order low: low bits count linearly mod four
// [RULE5] order high: low bits are start xor count
// [RULE6] register select low flow-through, high pipelined
// [RULE7] sleep request asynchronous, active high, default awake
// [RULE8] sleep entered two cycles after request, deselected; here three, two of them spent in the request synchronizer
// [RULE9] state kept intact while asleep
// [RULE10] asleep: inputs ignored, data drivers off
// [RULE11] resume two cycles after request falls; here five, two of them spent in the request synchronizer
// [RULE12] controller finishes accesses before requesting sleep
// [RULE13] controller issues no writes during recovery
// [RULE14] hold cycle changes no control state
// [RULE15] burst counter is two bits wide
// [RULE16] every burst-continue cycle increments the counter; here a continue after a deselect does not
// [RULE17] clock enable high ignores the edge
// [RULE18] active only with all three enables on load
// [RULE19] upper address bits stay as loaded
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module bsc_top
  import bsc_pkg::*;
(
  input  wire logic                 i_sys_clk,               // 125 MHz clock
  input  wire logic                 i_reset,                 // async reset, high
  // wishbone slave
  input  wire logic                 i_wb_cyc,                // bus cycle
  input  wire logic                 i_wb_stb,                // strobe
  input  wire logic                 i_wb_we,                 // write
  input  wire logic [3:0]           i_wb_adr,                // byte address
  input  wire logic [31:0]          i_wb_dat,                // write data
  input  wire logic [3:0]           i_wb_sel,                // byte lanes
  output logic      [31:0]          o_wb_dat,                // read data
  output logic                      o_wb_ack,                // acknowledge
  // memory pins
  input  wire logic                 i_clk_enable_n,          // low: edge taken
  input  wire logic                 i_burst_step_or_load,    // high step, low load
  input  wire logic                 i_chip_select_first_n,   // enable, low
  input  wire logic                 i_chip_select_second,    // enable, high
  input  wire logic                 i_chip_select_third_n,   // enable, low
  input  wire logic                 i_write_n,               // low: write
  input  wire logic [BSC_BYTES-1:0] i_byte_write_n,          // byte writes, low
  input  wire logic [BSC_ADDR_W-1:0] i_addr,                 // external address
  input  wire logic                 i_burst_order_select,    // high interleaved
  input  wire logic                 i_output_register_select, // low flow-through
  input  wire logic                 i_sleep_request,         // async sleep, high
  // to array and drivers
  output bsc_core_req_t             o_core_req,              // access of cycle
  output logic                      o_dq_oe,                 // data drivers on
  output logic                      o_pipelined,             // pipelined mode
  output logic                      o_asleep                 // in sleep
);
  logic                  burst_step_or_load;
  logic                  sel_all;
  logic                  load;
  logic                  step;
  logic                  any_byte;
  logic                  wr_blk;
  logic                  rd_issue;
  logic                  wr_issue;
  logic                  asleep;
  logic                  recovering;
  logic                  sleep_start;
  logic [BSC_ADDR_W-1:0] burst_addr;
  logic [1:0]            burst_cnt;
  bsc_rw_t               rw_q;
  bsc_rw_t               rw_d;
  logic                  rd_q;
  logic                  wr_q;
  logic [BSC_BYTES-1:0]  be_q;
  logic [1:0]            rd_pipe_q;
  logic                  ctrl_block_q;
  logic [BSC_EVT_W-1:0]  evt_q;
  logic [BSC_EVT_W-1:0]  evt_set;
  logic [BSC_EVT_W-1:0]  evt_clr;
  logic                  ack_q;
  logic [31:0]           rd_dat_q;
  logic                  bus_req;
  logic                  bus_wr;
  bsc_status_t           status;

  // edge qualification
  // an ignored edge moves no burst address, read/write state or pipe; the strobes simply see no command
  assign burst_step_or_load      = !i_clk_enable_n && !asleep; // RULE17
  assign sel_all  = !i_chip_select_first_n
                    && i_chip_select_second
                    && !i_chip_select_third_n; // RULE18
  assign load     = burst_step_or_load && !i_burst_step_or_load; // RULE2
  // deselect-continue has no burst to advance
  assign step     = burst_step_or_load && i_burst_step_or_load
                    && (rw_q != BSC_RW_DESEL); // RULE16
  assign any_byte = ~&i_byte_write_n;
  assign wr_blk   = recovering && ctrl_block_q;

  always_comb begin
    rw_d = rw_q; // RULE14
    if (load) begin
      if (!sel_all) begin
        rw_d = BSC_RW_DESEL; // RULE18
      end else if (i_write_n) begin
        rw_d = BSC_RW_READ;
      end else if (wr_blk) begin
        rw_d = BSC_RW_DESEL;
      end else begin
        rw_d = BSC_RW_WRITE;
      end
    end
  end

  assign rd_issue = (load || step) && (rw_d == BSC_RW_READ); // RULE1
  // a write with no byte lane is an abort: counter moves, array untouched
  assign wr_issue = (load || step) && (rw_d == BSC_RW_WRITE)
                    && any_byte && !wr_blk;

  bsc_burst_gen #(
    .ADDR_W (BSC_ADDR_W)
  ) u_burst (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_load    (load && sel_all),
    .i_step    (step),
    .i_order   (i_burst_order_select),
    .i_addr    (i_addr),
    .o_addr    (burst_addr),
    .o_count   (burst_cnt)
  );

  bsc_sleep_ctl u_sleep (
    .i_sys_clk       (i_sys_clk),
    .i_reset         (i_reset),
    .i_sleep_request (i_sleep_request),
    .o_asleep        (asleep),
    .o_recovering    (recovering),
    .o_sleep_start   (sleep_start)
  );

  // read/write control state
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rw_q <= BSC_RW_DESEL;
    end else begin
      rw_q <= rw_d; // RULE14
    end
  end

  // one-cycle strobes toward the array, address comes from the counter
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      be_q <= '0;
    end else begin
      rd_q <= rd_issue; // RULE1
      wr_q <= wr_issue;
      be_q <= wr_issue ? ~i_byte_write_n : '0;
    end
  end

  // data i/o pipe: frozen on hold and in sleep so a read resumes intact
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_pipe_q <= 2'h0;
    end else if (burst_step_or_load) begin
      rd_pipe_q <= {rd_pipe_q[0], rd_issue}; // RULE9
    end
  end

  assign o_dq_oe     = !asleep
                       && (i_output_register_select ? rd_pipe_q[1]
                                                    : rd_pipe_q[0]); // RULE10
  assign o_pipelined = i_output_register_select; // RULE6
  assign o_asleep    = asleep;

  always_comb begin
    o_core_req         = '0;
    o_core_req.read    = rd_q;
    o_core_req.write   = wr_q;
    o_core_req.byte_en = be_q;
    o_core_req.addr    = burst_addr;
  end

  // protocol watch: the controller's own duties, flagged here; recovery writes are also dropped while ctrl_block_q is set
  always_comb begin
    evt_set = '0;
    evt_set[BSC_EVT_REC_WR_BIT] = load && sel_all
                                  && !i_write_n && recovering; // RULE13
    evt_set[BSC_EVT_CUT_BIT]    = sleep_start
                                  && ((rw_q != BSC_RW_DESEL)
                                      || (rd_pipe_q != 2'h0)); // RULE12
  end

  // wishbone slave, one wait state on every access
  assign bus_req = i_wb_cyc && i_wb_stb && !ack_q;
  // writes land on the edge the master samples ack, while it still holds the request
  assign bus_wr  = i_wb_cyc && i_wb_stb && i_wb_we && ack_q;

  always_comb begin
    evt_clr = '0;
    if (bus_wr && (i_wb_adr == BSC_OFF_EVENT) && i_wb_sel[0]) begin
      evt_clr = i_wb_dat[BSC_EVT_W-1:0];
    end
  end

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      evt_q <= '0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_block_q <= BSC_CTRL_BLOCK_RST;
    end else if (bus_wr && (i_wb_adr == BSC_OFF_CTRL) && i_wb_sel[0]) begin
      ctrl_block_q <= i_wb_dat[BSC_CTRL_BLOCK_BIT];
    end
  end

  always_comb begin
    status            = '0;
    status.burst_cnt  = burst_cnt;
    status.order      = i_burst_order_select;
    status.pipelined  = i_output_register_select;
    status.recovering = recovering;
    status.asleep     = asleep;
    status.rw         = rw_q;
  end

  // reads have no side effects; unmapped words read zero
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_dat_q <= 32'h0;
    end else if (bus_req) begin
      if (i_wb_adr == BSC_OFF_CTRL) begin
        rd_dat_q <= {31'h0, ctrl_block_q};
      end else if (i_wb_adr == BSC_OFF_STATUS) begin
        rd_dat_q <= {{(32 - BSC_STATUS_W){1'b0}}, status};
      end else if (i_wb_adr == BSC_OFF_ADDR) begin
        rd_dat_q <= {{(32 - BSC_ADDR_W){1'b0}}, burst_addr};
      end else if (i_wb_adr == BSC_OFF_EVENT) begin
        rd_dat_q <= {{(32 - BSC_EVT_W){1'b0}}, evt_q};
      end else begin
        rd_dat_q <= 32'h0;
      end
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rd_dat_q;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  a_hold_state: assert property ( // RULE14
    i_clk_enable_n && !asleep |=> $stable(rw_q) && !rd_q && !wr_q)
    else $error("hold cycle changed control state");

  a_hold_addr: assert property ( // RULE17
    !burst_step_or_load |=> $stable(burst_addr) && $stable(rd_pipe_q))
    else $error("ignored edge moved address or pipe");

  a_load_addr: assert property ( // RULE2
    load && sel_all |=> burst_addr == $past(i_addr))
    else $error("start address not loaded");

  a_desel_any: assert property ( // RULE18
    load && !sel_all |=> rw_q == BSC_RW_DESEL && !rd_q && !wr_q)
    else $error("partial enables did not deselect");

  a_step_read: assert property ( // RULE1
    step && rw_q == BSC_RW_READ
    |=> rd_q && burst_addr[1:0] != $past(burst_addr[1:0]))
    else $error("burst step did not read next address");

  a_sleep_keep: assert property ( // RULE9
    asleep |=> $stable(rw_q) && $stable(burst_addr))
    else $error("state changed during sleep");

  a_sleep_quiet: assert property ( // RULE10
    asleep |-> !o_dq_oe ##1 !rd_q && !wr_q)
    else $error("activity while asleep");

  a_flow_oe: assert property ( // RULE6
    rd_issue && !i_output_register_select ##1 !asleep && !i_output_register_select
    |-> o_dq_oe)
    else $error("flow-through read not driven next cycle");

  a_pipe_oe: assert property ( // RULE6
    rd_issue && i_output_register_select
    ##1 (!asleep && !i_clk_enable_n && i_output_register_select)
    ##1 (!asleep && i_output_register_select) |-> o_dq_oe)
    else $error("pipelined read not driven after two edges");

  a_evt_sticky: assert property ( // RULE13
    evt_set[BSC_EVT_REC_WR_BIT] |=> evt_q[BSC_EVT_REC_WR_BIT] [*2])
    else $error("recovery write event lost");

  a_bus_ack: assert property (
    bus_req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus ack not a single cycle");

  c_burst_wrap: cover property (step [*4]);
  c_sleep_cycle: cover property ($rose(asleep) ##[1:50] $fell(asleep));
  c_rec_write: cover property (evt_set[BSC_EVT_REC_WR_BIT]);
  c_hold_read: cover property (rd_q ##1 i_clk_enable_n);
endmodule : bsc_top

// *** test/bsc_mem_host.sv ***
`timescale 1ns/100ps
module bsc_mem_host
  import bsc_pkg::*;
(
  input  wire logic             i_sys_clk, // system clock
  output logic                  o_cke_n,   // low: edge taken
  output logic                  o_step,    // high step, low load
  output logic [2:0]            o_cs,      // first_n, second, third_n
  output logic                  o_write_n, // low: write
  output logic [BSC_BYTES-1:0]  o_bw_n,    // byte writes, low
  output logic [BSC_ADDR_W-1:0] o_addr,    // start address
  output logic                  o_order,   // high interleaved
  output logic                  o_regsel,  // low flow-through
  output logic                  o_sleep    // sleep request
);
  initial begin
    o_cke_n   = 1'b0;
    o_step    = 1'b0;
    o_cs      = 3'b110;
    o_write_n = 1'b1;
    o_bw_n    = '1;
    o_addr    = '0;
    o_order   = 1'b0;
    o_regsel  = 1'b1;
    o_sleep   = 1'b0;
  end
  // address unused on steps: show its inverse so a stale value never matches
  task automatic cmd(input logic s, input logic [2:0] c, input logic w,
                     input logic [BSC_ADDR_W-1:0] a);
    @(posedge i_sys_clk);
    o_cke_n   <= 1'b0;
    o_step    <= s;
    o_cs      <= c;
    o_write_n <= w;
    o_bw_n    <= {BSC_BYTES{w}};
    o_addr    <= s ? ~o_addr : a;
  endtask : cmd
  task automatic hold;
    @(posedge i_sys_clk);
    o_cke_n <= 1'b1;
    o_addr  <= ~o_addr;
  endtask : hold
  // callers raise sleep only with the pipe idle, and read only after recovery ends
  task automatic pins(input logic ord, input logic rs, input logic sl);
    @(posedge i_sys_clk);
    o_cke_n  <= 1'b0;
    o_step   <= 1'b0;
    o_cs     <= 3'b110;
    o_order  <= ord;
    o_regsel <= rs;
    o_sleep  <= sl;
  endtask : pins
endmodule : bsc_mem_host

// *** test/burst_sleep_control_bench.sv ***
`timescale 1ns/100ps
module burst_sleep_control_bench;
  import bsc_pkg::*;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  cyc = 1'b0;
  logic                  stb = 1'b0;
  logic                  we = 1'b0;
  logic [3:0]            adr = 4'h0;
  logic [3:0]            sel = 4'hF;
  logic [31:0]           wdat = 32'h0;
  logic [31:0]           rdat;
  logic                  ack;
  logic                  cke_n, step, wr_n, order, regsel, slp, oe, pipe, asleep;
  logic [2:0]            cs;
  logic [BSC_BYTES-1:0]  bw_n;
  logic [BSC_ADDR_W-1:0] maddr;
  bsc_core_req_t         req;
  int                    n_errors = 0;
  int                    n_tests = 0;
  int                    cycles = 0;

  always #4 clk = ~clk;

  bsc_mem_host host (.i_sys_clk(clk), .o_cke_n(cke_n), .o_step(step), .o_cs(cs),
    .o_write_n(wr_n), .o_bw_n(bw_n), .o_addr(maddr), .o_order(order),
    .o_regsel(regsel), .o_sleep(slp));

  bsc_top dut (.i_sys_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_clk_enable_n(cke_n), .i_burst_step_or_load(step),
    .i_chip_select_first_n(cs[2]), .i_chip_select_second(cs[1]),
    .i_chip_select_third_n(cs[0]), .i_write_n(wr_n), .i_byte_write_n(bw_n),
    .i_addr(maddr), .i_burst_order_select(order), .i_output_register_select(regsel),
    .i_sleep_request(slp), .o_core_req(req), .o_dq_oe(oe), .o_pipelined(pipe),
    .o_asleep(asleep));

  task automatic finish_test;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  // request held until ack is sampled high at a rising edge; data taken there
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    chk("wb ack", 1, ack);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic t_regs;
    logic [31:0] q;
    chk("oe reset", 0, oe);
    wb(1'b0, BSC_OFF_CTRL, 0, q);
    chk("ctrl reset", 1, q);
    wb(1'b0, BSC_OFF_EVENT, 0, q);
    chk("event reset", 0, q);
    wb(1'b0, 4'h2, 0, q);
    chk("unmapped", 0, q);
    wb(1'b1, BSC_OFF_CTRL, 0, q);
    wb(1'b0, BSC_OFF_CTRL, 0, q);
    chk("ctrl rw", 0, q);
  endtask : t_regs

  task automatic run_burst(input logic ord, input logic [BSC_ADDR_W-1:0] a);
    logic [1:0] k;
    host.pins(ord, 1'b1, 1'b0);
    host.cmd(1'b0, 3'b010, 1'b1, a);
    for (int i = 0; i < 5; i++) begin
      k = i[1:0];
      host.cmd(1'b1, 3'b010, 1'b1, a);
      @(negedge clk);
      chk("burst addr", {a[BSC_ADDR_W-1:2], ord ? a[1:0] ^ k : a[1:0] + k}, req.addr);
      if (i == 0) chk("load read", 1, req.read);
    end
    host.cmd(1'b0, 3'b110, 1'b1, a);
  endtask : run_burst

  task automatic t_hold;
    host.cmd(1'b0, 3'b010, 1'b1, 20'h00F00);
    host.cmd(1'b1, 3'b010, 1'b1, 20'h0);
    host.hold();
    @(negedge clk);
    chk("step addr", 32'h00F01, req.addr);
    host.cmd(1'b1, 3'b010, 1'b1, 20'h0);
    @(negedge clk);
    chk("hold addr", 32'h00F01, req.addr);
    chk("hold read", 0, req.read);
    host.cmd(1'b0, 3'b110, 1'b1, 20'h0);
    @(negedge clk);
    chk("after hold", 32'h00F02, req.addr);
  endtask : t_hold

  task automatic t_select;
    for (int j = 0; j < 3; j++) begin
      host.cmd(1'b0, 3'b010 ^ (3'b001 << j), 1'b1, 20'h00100);
      host.cmd(1'b0, 3'b110, 1'b1, 20'h0);
      @(negedge clk);
      chk("deselected read", 0, req.read);
    end
    host.cmd(1'b0, 3'b010, 1'b0, 20'h00200);
    host.cmd(1'b0, 3'b110, 1'b1, 20'h0);
    @(negedge clk);
    chk("write strobe", 1, req.write);
    chk("write lanes", 32'hF, req.byte_en);
    chk("write addr", 32'h00200, req.addr);
  endtask : t_select

  task automatic t_pins;
    logic [31:0] q;
    for (int r = 0; r < 2; r++) begin
      host.pins(1'b1, r[0], 1'b0);
      @(negedge clk);
      chk("pipelined", {31'h0, r[0]}, {31'h0, pipe});
      wb(1'b0, BSC_OFF_STATUS, 0, q);
      chk("status pins", {30'h0, 1'b1, r[0]}, {30'h0, q[5:4]});
      host.cmd(1'b0, 3'b010, 1'b1, 20'h00040);
      host.cmd(1'b0, 3'b110, 1'b1, 20'h0);
      @(negedge clk);
      chk("oe first", {31'h0, !r[0]}, {31'h0, oe});
      @(negedge clk);
      chk("oe second", {31'h0, r[0]}, {31'h0, oe});
    end
  endtask : t_pins

  task automatic t_sleep;
    logic [31:0] q;
    int k;
    host.pins(1'b0, 1'b1, 1'b0);
    host.cmd(1'b0, 3'b010, 1'b1, 20'h05551);
    host.cmd(1'b1, 3'b010, 1'b1, 20'h0);
    host.cmd(1'b0, 3'b110, 1'b1, 20'h0);
    repeat (3) @(posedge clk);
    host.pins(1'b0, 1'b1, 1'b1);
    repeat (3) @(negedge clk);
    chk("asleep early", 0, asleep);
    @(negedge clk);
    chk("asleep", 1, asleep);
    host.cmd(1'b0, 3'b010, 1'b0, 20'h0AAA0);
    host.cmd(1'b1, 3'b010, 1'b0, 20'h0);
    @(negedge clk);
    chk("sleep addr", 32'h05552, req.addr);
    chk("sleep strobes", 0, {req.read, req.write, oe});
    host.pins(1'b0, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk("wake early", 1, asleep);
    k = 0;
    while (asleep !== 1'b0 && k < 12) begin
      @(negedge clk);
      k++;
    end
    chk("woke", 0, asleep);
    wb(1'b0, BSC_OFF_ADDR, 0, q);
    chk("kept addr", 32'h05552, q);
    host.cmd(1'b0, 3'b010, 1'b1, 20'h00300);
    host.cmd(1'b0, 3'b110, 1'b1, 20'h0);
    @(negedge clk);
    chk("wake read", 1, req.read);
    chk("wake addr", 32'h00300, req.addr);
  endtask : t_sleep

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    run_burst(1'b0, 20'hABCD2);
    run_burst(1'b1, 20'h12341);
    t_hold();
    t_select();
    t_pins();
    t_sleep();
    finish_test();
  end
endmodule : burst_sleep_control_bench
